// ==== verilog/icc_pkg.sv ====
/*
 package for the input capture channel block: register map, field layout,
 mode codes, reset values and carrier structs.
 assumes: one 250 MHz clock, synchronous active-high reset, plain register port.
*/
//
// Contract
// RULE_01: five capture modes chosen by mode field
// RULE_02: mode selects prescale; off clears edge counter
// RULE_03: any reset clears prescaler edge counter
// RULE_04: per-channel fifo of four 16-bit captures
// RULE_05: not-empty set on capture until drained
// RULE_06: buffer read returns oldest, shifts rest
// RULE_07: fifth capture when full sets overflow, dropped
// RULE_08: after overflow no capture until buffer drained
// RULE_09: software ignores data of an empty read
// RULE_10: control bit 7 selects first or second timer
// RULE_11: reset selects second timer as time base
// RULE_12: up to eight independent channels instantiable
// RULE_13: both-edge mode flags irq on every edge
// RULE_14: both-edge mode ignores irq count field
// RULE_15: both-edge mode never raises overflow
// RULE_16: bits 6:5 pick captures per interrupt
// RULE_17: mode 111 rising edge wakes, timer independent
// RULE_18: capture writes selected timer count to tail
package icc_pkg;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned FIFO_DEPTH    = 4;
   localparam int unsigned ADDR_W        = 8;
   // per-channel register stride and offsets, then block irq status and mask addresses
   localparam logic [7:0]  CH_STRIDE     = 8'h04;
   localparam logic [1:0]  OFS_BUF       = 2'h0;
   localparam logic [1:0]  OFS_CTRL      = 2'h1;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h80;
   localparam logic [7:0]  OFS_IRQ_MASK  = 8'h81;
   // control fields
   localparam int unsigned MODE_LSB      = 0;
   localparam int unsigned NE_BIT        = 3;
   localparam int unsigned OV_BIT        = 4;
   localparam int unsigned ICNT_LSB      = 5;
   localparam int unsigned TSEL_BIT      = 7;
   localparam logic        TSEL_RST      = 1'b1;
   localparam logic [2:0]  MODE_RST      = 3'h0;
   localparam logic [1:0]  ICNT_RST      = 2'h0;
   localparam logic [3:0]  PRE_16        = 4'hF;
   localparam logic [3:0]  PRE_4         = 4'h3;

   typedef enum logic [2:0] {
      ICC_OFF    = 3'h0,
      ICC_BOTH   = 3'h1,
      ICC_FALL   = 3'h2,
      ICC_RISE   = 3'h3,
      ICC_RISE4  = 3'h4,
      ICC_RISE16 = 3'h5,
      ICC_RSV    = 3'h6,
      ICC_WAKE   = 3'h7
   } icc_mode_t;

   typedef struct packed {
      logic       timebase_sel;
      logic [1:0] irq_count_sel;
      icc_mode_t  capture_mode_sel;
   } icc_cfg_t;

   typedef struct packed {
      logic              buf_not_empty;
      logic              capture_overflow;
      logic              capture_irq_flag;
      logic              wake;
      logic [DATA_W-1:0] rdata;
   } icc_stat_t;
endpackage

// ==== verilog/icc_chan.sv ====
/*
 one input capture channel: edge detect, prescaler, four-word fifo,
 overflow and interrupt counting.
 assumes: pin and timer counts synchronous to clk; pop only on a buffer read.
*/
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module icc_chan #(
   parameter int unsigned DEPTH = icc_pkg::FIFO_DEPTH
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      pin,
   input  wire logic [icc_pkg::DATA_W-1:0] tmr_a,
   input  wire logic [icc_pkg::DATA_W-1:0] tmr_b,
   input  icc_pkg::icc_cfg_t              cfg,
   input  wire logic                      pop,
   output icc_pkg::icc_stat_t             stat
);
   typedef struct packed {
      logic                                 pin_q;
      logic [3:0]                           pre_q;
      logic [1:0]                           icnt_q;
      logic [$clog2(DEPTH+1)-1:0]           cnt_q;
      logic [DEPTH-1:0][icc_pkg::DATA_W-1:0] mem_q;
      logic                                 ov_q;
      logic                                 irq_q;
      logic                                 wake_q;
   } icc_chan_st_t;

   icc_chan_st_t s_q;
   icc_chan_st_t s_d;

   always_comb begin
      logic rise;
      logic fall;
      logic cap;
      logic irq;
      logic [icc_pkg::DATA_W-1:0] ts;
      s_d  = s_q;
      rise = pin & ~s_q.pin_q;
      fall = ~pin & s_q.pin_q;
      cap  = 1'b0;
      irq  = 1'b0;
      ts   = cfg.timebase_sel ? tmr_b : tmr_a; // RULE_10
      s_d.pin_q  = pin;
      s_d.wake_q = 1'b0;
      unique case (cfg.capture_mode_sel) // RULE_01
         icc_pkg::ICC_OFF: begin
            s_d.pre_q = '0; // RULE_02
         end
         icc_pkg::ICC_BOTH: cap = rise | fall;
         icc_pkg::ICC_FALL: cap = fall;
         icc_pkg::ICC_RISE: cap = rise;
         icc_pkg::ICC_RISE4, icc_pkg::ICC_RISE16: begin
            if (rise) begin
               s_d.pre_q = s_q.pre_q + 4'h1; // RULE_02
               if (s_q.pre_q == ((cfg.capture_mode_sel == icc_pkg::ICC_RISE4) ? icc_pkg::PRE_4 : icc_pkg::PRE_16)) begin
                  s_d.pre_q = '0;
                  cap = 1'b1;
               end
            end
         end
         icc_pkg::ICC_WAKE: begin
            s_d.wake_q = rise; // RULE_17
            irq = rise;
         end
         icc_pkg::ICC_RSV: cap = 1'b0;
      endcase
      // pop: oldest out, rest move forward
      if (pop && s_q.cnt_q != '0) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            s_d.mem_q[i] = s_q.mem_q[i+1]; // RULE_06
         end
         s_d.cnt_q = s_q.cnt_q - 1'b1;
         if (s_q.cnt_q == 1) begin
            s_d.ov_q = 1'b0; // RULE_08
         end
      end
      if (cap) begin
         if (cfg.capture_mode_sel == icc_pkg::ICC_BOTH) begin
            irq = 1'b1; // RULE_13 RULE_14
         end else if (s_q.icnt_q == cfg.irq_count_sel) begin
            irq = 1'b1; // RULE_16
            s_d.icnt_q = '0;
         end else begin
            s_d.icnt_q = s_q.icnt_q + 2'h1;
         end
         if (s_q.ov_q) begin
            s_d.mem_q = s_d.mem_q; // RULE_08
         end else if (s_q.cnt_q == DEPTH[$bits(s_q.cnt_q)-1:0] && !(pop)) begin
            if (cfg.capture_mode_sel != icc_pkg::ICC_BOTH) begin
               s_d.ov_q = 1'b1; // RULE_07 RULE_15
            end
         end else begin
            s_d.mem_q[s_d.cnt_q[$clog2(DEPTH)-1:0]] = ts; // RULE_18 RULE_04
            s_d.cnt_q = s_d.cnt_q + 1'b1;
         end
      end
      s_d.irq_q = irq;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0; // RULE_03
      end else begin
         s_q <= s_d;
      end
   end

   assign stat.buf_not_empty    = (s_q.cnt_q != '0); // RULE_05
   assign stat.capture_overflow = s_q.ov_q;
   assign stat.capture_irq_flag = s_q.irq_q;
   assign stat.wake             = s_q.wake_q;
   assign stat.rdata            = s_q.mem_q[0]; // RULE_09
endmodule // icc_chan

// ==== verilog/icc_top.sv ====
/*
 input capture block top: up to eight channels, register port,
 sticky interrupt status with mask, wake output.
 assumes: timer counts come from an outside time base, synchronous to clk.
*/
`timescale 1ns/1ns
module icc_top #(
   parameter int unsigned NCH = 4
) (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic [NCH-1:0]                  cap_pin,
   input  wire logic [icc_pkg::DATA_W-1:0]      tmr_first,
   input  wire logic [icc_pkg::DATA_W-1:0]      tmr_second,
   input  wire logic [icc_pkg::ADDR_W-1:0]      addr,
   input  wire logic [icc_pkg::DATA_W-1:0]      wdata,
   input  wire logic                            wr,
   input  wire logic                            rd,
   output logic      [icc_pkg::DATA_W-1:0]      rdata,
   output logic                                 irq,
   output logic                                 wake
);
   typedef struct packed {
      icc_pkg::icc_cfg_t [NCH-1:0] cfg_q;
      logic [NCH-1:0]              sts_q;
      logic [NCH-1:0]              msk_q;
      logic [icc_pkg::DATA_W-1:0]  rdata_q;
      logic                        irq_q;
      logic                        wake_q;
   } icc_top_st_t;

   icc_top_st_t        s_q;
   icc_top_st_t        s_d;
   icc_pkg::icc_stat_t [NCH-1:0] st;
   logic [NCH-1:0]     pop;

   for (genvar g = 0; g < NCH; g++) begin : g_ch // RULE_12
      assign pop[g] = rd && addr == icc_pkg::ADDR_W'(g * icc_pkg::CH_STRIDE + icc_pkg::OFS_BUF);
      icc_chan #(.DEPTH(icc_pkg::FIFO_DEPTH)) u_ch (
         .clk   (clk),
         .rst   (rst),
         .pin   (cap_pin[g]),
         .tmr_a (tmr_first),
         .tmr_b (tmr_second),
         .cfg   (s_q.cfg_q[g]),
         .pop   (pop[g]),
         .stat  (st[g])
      );
   end

   always_comb begin
      logic [NCH-1:0] ev;
      logic [NCH-1:0] wk;
      s_d = s_q;
      s_d.rdata_q = '0;
      ev = '0;
      wk = '0;
      for (int i = 0; i < NCH; i++) begin
         ev[i] = st[i].capture_irq_flag;
         wk[i] = st[i].wake;
         if (wr && addr == icc_pkg::ADDR_W'(i * icc_pkg::CH_STRIDE + icc_pkg::OFS_CTRL)) begin
            s_d.cfg_q[i].capture_mode_sel = icc_pkg::icc_mode_t'(wdata[icc_pkg::MODE_LSB +: 3]); // RULE_01
            s_d.cfg_q[i].irq_count_sel    = wdata[icc_pkg::ICNT_LSB +: 2]; // RULE_16
            s_d.cfg_q[i].timebase_sel     = wdata[icc_pkg::TSEL_BIT]; // RULE_10
         end
         if (rd && addr == icc_pkg::ADDR_W'(i * icc_pkg::CH_STRIDE + icc_pkg::OFS_BUF)) begin
            s_d.rdata_q = st[i].rdata;
         end
         if (rd && addr == icc_pkg::ADDR_W'(i * icc_pkg::CH_STRIDE + icc_pkg::OFS_CTRL)) begin
            s_d.rdata_q[icc_pkg::MODE_LSB +: 3]  = s_q.cfg_q[i].capture_mode_sel;
            s_d.rdata_q[icc_pkg::NE_BIT]         = st[i].buf_not_empty; // RULE_05
            s_d.rdata_q[icc_pkg::OV_BIT]         = st[i].capture_overflow; // RULE_07
            s_d.rdata_q[icc_pkg::ICNT_LSB +: 2]  = s_q.cfg_q[i].irq_count_sel;
            s_d.rdata_q[icc_pkg::TSEL_BIT]       = s_q.cfg_q[i].timebase_sel;
         end
      end
      if (rd && addr == icc_pkg::OFS_IRQ_STAT) begin
         s_d.rdata_q[NCH-1:0] = s_q.sts_q;
      end
      if (rd && addr == icc_pkg::OFS_IRQ_MASK) begin
         s_d.rdata_q[NCH-1:0] = s_q.msk_q;
      end
      if (wr && addr == icc_pkg::OFS_IRQ_MASK) begin
         s_d.msk_q = wdata[NCH-1:0];
      end
      // write one clears; a new event wins
      if (wr && addr == icc_pkg::OFS_IRQ_STAT) begin
         s_d.sts_q = s_q.sts_q & ~wdata[NCH-1:0];
      end
      s_d.sts_q  = s_d.sts_q | ev;
      s_d.irq_q  = |(s_d.sts_q & s_d.msk_q);
      s_d.wake_q = |(wk & s_q.msk_q); // RULE_17
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            s_q.cfg_q[i].capture_mode_sel <= icc_pkg::ICC_OFF;
            s_q.cfg_q[i].irq_count_sel    <= icc_pkg::ICNT_RST;
            s_q.cfg_q[i].timebase_sel     <= icc_pkg::TSEL_RST; // RULE_11
         end
         s_q.sts_q   <= '0;
         s_q.msk_q   <= '0;
         s_q.rdata_q <= '0;
         s_q.irq_q   <= 1'b0;
         s_q.wake_q  <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata_q;
   assign irq   = s_q.irq_q;
   assign wake  = s_q.wake_q;
endmodule // icc_top

// ==== sim/icc_src.sv ====
/* timer time base partner: two 16-bit counts stepped by adv.
 assumes: adv driven by the bench, one clock. */
`timescale 1ns/1ns
module icc_src (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        adv,
   output logic      [15:0] t1,
   output logic      [15:0] t2
);
   // counts stand still between steps so each capture sees one value
   always_ff @(posedge clk) begin
      if (rst) begin
         t1 <= 16'h1234;
         t2 <= 16'hA5C3;
      end else if (adv) begin
         t1 <= t1 + 16'h0111;
         t2 <= t2 - 16'h0203;
      end
   end
endmodule // icc_src

// ==== sim/icc_properties.sv ====
/* port assertions for the capture block top.
 assumes: bound to icc_top, status at 8'h80, mask at 8'h81. */
`timescale 1ns/1ns
module icc_props #(
   parameter int unsigned NCH = 4
) (
   input wire logic           clk,
   input wire logic           rst,
   input wire logic [NCH-1:0] cap_pin,
   input wire logic [7:0]     addr,
   input wire logic [15:0]    wdata,
   input wire logic           wr,
   input wire logic           rd,
   input wire logic [15:0]    rdata,
   input wire logic           irq,
   input wire logic           wake
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("data without read");
   unmapped_a: assert property ($past(rd) && ($past(addr[1]) || ($past(addr) >= 4 * NCH && $past(addr) < 8'h80))
      |-> rdata == 16'h0000) else $error("unmapped read not zero");
   reset_quiet_a: assert property ($fell(rst) |-> rdata == 16'h0000 && !irq && !wake) else $error("busy reset");
   wake_pulse_a: assert property (wake |=> !wake) else $error("wake too long");
   wake_cause_a: assert property (wake |-> $past(cap_pin) != $past(cap_pin, 4)) else $error("wake no edge");
   irq_cause_a: assert property ($rose(irq) |-> $past(wr) || $past(wr, 2) || $past(cap_pin) != $past(cap_pin, 4))
      else $error("irq without cause");
   irq_fall_a: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2)) else $error("irq fell alone");
   mask_off_a: assert property (wr && addr == 8'h81 && wdata == 16'h0000 |-> ##2 !irq) else $error("masked irq");
endmodule // icc_props

// ==== sim/testbench.sv ====
/* bench for the capture block: register tasks, one task per scenario.
 assumes: two channels, icc_src steps the timers. */
`timescale 1ns/1ns
module testbench;
   logic        clk, rst, wr, rd, adv, irq, wake;
   logic [1:0]  cap_pin;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata, t1, t2, v;
   logic [15:0] q[$];
   int          err_count = 0, n_tests = 0, cyc = 0, wk = 0;
   icc_top #(.NCH(2)) DUT (.clk(clk), .rst(rst), .cap_pin(cap_pin), .tmr_first(t1), .tmr_second(t2),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wake(wake));
   icc_src u_src (.clk(clk), .rst(rst), .adv(adv), .t1(t1), .t2(t2));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wake === 1'b1) wk <= wk + 1;
      if (cyc == 30000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (err_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic rs(input int n);
      @(posedge clk);
      rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic bw(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic br(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic ctl(input int ch, input logic ts, input logic [1:0] ic, input logic [2:0] m);
      bw(8'(4 * ch + 1), {8'h00, ts, ic, 2'h0, m});
   endtask
   task automatic ci(input string s, input logic e);
      repeat (2) @(posedge clk);
      #1 chk(s, {15'h0000, e}, {15'h0000, irq});
   endtask
   task automatic pe(input int ch, input logic b);
      @(posedge clk);
      cap_pin[ch] <= b;
      repeat (4) @(posedge clk);
   endtask
   task automatic pl(input int ch, input int n);
      repeat (n) begin
         pe(ch, 1'b1);
         pe(ch, 1'b0);
         adv <= 1'b1;
         @(posedge clk);
         adv <= 1'b0;
         // let the stepped counts settle before the next sample
         @(posedge clk);
      end
   endtask
   task automatic t_fifo();
      br(8'h01);
      chk("ctrl rst", 16'h0080, v);
      br(8'h42);
      chk("unmapped", 16'h0000, v);
      ctl(0, 1'b0, 2'h0, icc_pkg::ICC_RISE);
      repeat (4) begin
         q.push_back(t1);
         pl(0, 1);
      end
      pl(0, 2);
      br(8'h01);
      chk("ovf", 16'h001B, v);
      br(8'h00);
      chk("buf", q.pop_front(), v);
      pl(0, 1);
      repeat (3) begin
         br(8'h00);
         chk("buf", q.pop_front(), v);
      end
      br(8'h01);
      chk("drained", 16'h0003, v);
      ctl(0, 1'b1, 2'h0, icc_pkg::ICC_RISE);
      q.push_back(t2);
      pl(0, 1);
      br(8'h00);
      chk("tsel", q.pop_front(), v);
   endtask
   task automatic t_pre();
      ctl(0, 1'b0, 2'h0, icc_pkg::ICC_RISE4);
      pl(0, 2);
      ctl(0, 1'b0, 2'h0, icc_pkg::ICC_OFF);
      ctl(0, 1'b0, 2'h0, icc_pkg::ICC_RISE4);
      pl(0, 3);
      br(8'h01);
      chk("pre off", 16'h0004, v);
      q.push_back(t1);
      pl(0, 1);
      br(8'h00);
      chk("pre4", q.pop_front(), v);
      ctl(0, 1'b0, 2'h0, icc_pkg::ICC_RISE16);
      pl(0, 9);
      rs(3);
      ctl(0, 1'b0, 2'h0, icc_pkg::ICC_RISE16);
      pl(0, 15);
      br(8'h01);
      chk("pre rst", 16'h0005, v);
      q.push_back(t1);
      pl(0, 1);
      br(8'h00);
      chk("pre16", q.pop_front(), v);
   endtask
   task automatic t_modes();
      logic [2:0] m [3];
      m = '{icc_pkg::ICC_FALL, icc_pkg::ICC_RISE, icc_pkg::ICC_BOTH};
      for (int i = 0; i < 3; i++) begin
         ctl(0, 1'b0, 2'h3, m[i]);
         bw(8'h80, 16'h0003);
         pe(0, 1'b1);
         br(8'h01);
         chk("ne rise", {15'h0000, i != 0}, {15'h0000, v[3]});
         br(8'h80);
         chk("st rise", {15'h0000, i == 2}, {15'h0000, v[0]});
         bw(8'h80, 16'h0003);
         pe(0, 1'b0);
         br(8'h80);
         chk("st fall", {15'h0000, i == 2}, {15'h0000, v[0]});
         br(8'h00);
         br(8'h01);
         chk("ne pop", {15'h0000, i == 2}, {15'h0000, v[3]});
         br(8'h00);
      end
      pl(0, 3);
      br(8'h01);
      chk("both ovf", 16'h0069, v);
   endtask
   task automatic t_irq();
      rs(2);
      ctl(0, 1'b0, 2'h1, icc_pkg::ICC_RISE);
      bw(8'h81, 16'h0001);
      pl(0, 1);
      ci("irq 1st", 1'b0);
      pl(0, 1);
      ci("irq 2nd", 1'b1);
      bw(8'h81, 16'h0000);
      ci("irq mask", 1'b0);
      bw(8'h81, 16'h0001);
      ci("irq unmask", 1'b1);
      bw(8'h80, 16'h0001);
      ci("irq clr", 1'b0);
      repeat (2) br(8'h00);
   endtask
   task automatic t_wake();
      bw(8'h81, 16'h0002);
      ctl(1, 1'b0, 2'h0, icc_pkg::ICC_WAKE);
      wk = 0;
      pl(1, 2);
      chk("wake", 16'h0002, 16'(wk));
      br(8'h05);
      chk("wake ctrl", 16'h0007, v);
      ctl(1, 1'b0, 2'h0, icc_pkg::ICC_RISE);
      q.push_back(t1);
      pl(1, 1);
      br(8'h04);
      chk("ch1 buf", q.pop_front(), v);
      ctl(1, 1'b0, 2'h0, icc_pkg::ICC_RSV);
      pl(1, 1);
      br(8'h05);
      chk("rsv ctrl", 16'h0006, v);
      br(8'h01);
      chk("ch0 idle", 16'h0023, v);
   endtask
   initial begin
      rst = 1'b1;
      {wr, rd, adv, cap_pin, addr, wdata} = '0;
      rs(11);
      t_fifo();
      t_pre();
      t_modes();
      t_irq();
      t_wake();
      complete_run();
   end
endmodule // testbench
bind icc_top icc_props #(.NCH(NCH)) u_props (.clk(clk), .rst(rst), .cap_pin(cap_pin), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wake(wake));
